// [logic/iocr_top.sv]
// Input overcurrent response, warning and turn-on delay control
`timescale 1ns/100ps
// How it works
// [RL1] The action field selects continue for 00 and disable-then-retry for 11, other codes act as continue.
// [RL2] A declared fault always pulls the alert low and sets the sticky fault status bit.
// [RL3] Retry code 000 keeps a disabled output off until the enable is cycled, an outside fault forces shutdown, or reset.
// [RL4] Retry code 111 restarts without limit until enable drops or an outside fault forces shutdown.
// [RL5] Restart attempts are spaced by the delay coded in the low three bits.
// [RL6] The retry delay is zero for 000, 25 ms per step for 001 to 110 and 175 ms for 111.
// [RL7] Protection compares the synthesized input current reading, not a sensed current.
// [RL8] The response register resets to 04h.
// [RL9] The warning limit is a signed 16-bit value at 10 mA per step.
// [RL10] The warning limit resets to 3A98h.
// [RL11] After enable the ramp start waits the turn-on delay in 10 us steps.
// [RL12] The turn-on delay resets to 0000h.
// [RL13] Commands are only accepted on page 00h and one copy is kept.
// [RL14] A fault is declared when the reading exceeds a signed fault limit that resets to 03E8h.
// [RL15] A reading above the warning limit sets a warning and the alert without disabling the output.
module iocr_top
	import iocr_pkg::*;
(
	input  wire logic        clk,                    // System clock, 100 MHz
	input  wire logic        reset,                  // Synchronous reset, active high
	input  wire iocr_cmd_t   cmd,                    // Command port from the bus engine
	input  wire logic [15:0] input_current_reading,  // Synthesized input current, 10 mA steps
	input  wire logic        enable,                 // Enable pin and operation command combined
	input  wire logic        shutdown_fault,         // Other fault forcing shutdown
	input  wire logic        clear_faults,           // Clears sticky status bits
	output iocr_rsp_t        rsp,                    // Command answer
	output logic             alert_out_n,            // Alert, active low
	output logic             output_enable,          // Output stage on
	output logic             ramp_start,             // One-cycle pulse starting the rise
	output logic             oc_fault_status,        // Sticky input overcurrent fault
	output logic             oc_warn_status          // Sticky input overcurrent warning
);
	logic [7:0]  input_overcurrent_response_reg;
	logic [15:0] input_overcurrent_warning_limit_reg;
	logic [15:0] input_overcurrent_fault_limit_reg;
	logic [15:0] turn_on_delay_reg;
	iocr_state_t state_reg, state_next;
	iocr_rsp_t   rsp_reg;
	logic        alert_n_reg, out_en_reg, ramp_reg, fault_st_reg, warn_st_reg;
	logic        page_ok, wr_hit;
	logic        fault_now, warn_now;
	logic [1:0]  fault_action_field;
	logic [2:0]  retry_code, delay_code;
	logic        timer_load, timer_busy;
	logic [31:0] timer_count, retry_cycles, ton_cycles;

	// ****************************************
	// Register access
	// ****************************************
	assign page_ok = (cmd.page == PAGE_ZERO);  // see [RL13]
	assign wr_hit  = cmd.write && page_ok;

	always_ff @(posedge clk) begin
		if (reset) begin
			input_overcurrent_response_reg      <= RESPONSE_RESET;     // see [RL8]
			input_overcurrent_warning_limit_reg <= WARN_LIMIT_RESET;   // see [RL10]
			input_overcurrent_fault_limit_reg   <= FAULT_LIMIT_RESET;  // see [RL14]
			turn_on_delay_reg                   <= TURN_ON_DELAY_RESET;    // see [RL12]
		end else if (wr_hit) begin
			case (cmd.command)
				CMD_INPUT_OVERCURRENT_RESPONSE: begin
					input_overcurrent_response_reg <= cmd.wdata[7:0];
				end
				CMD_INPUT_OVERCURRENT_WARN_LIMIT: begin
					input_overcurrent_warning_limit_reg <= cmd.wdata;
				end
				CMD_INPUT_OVERCURRENT_FAULT_LIMIT: begin
					input_overcurrent_fault_limit_reg <= cmd.wdata;
				end
				CMD_TURN_ON_DELAY: begin
					turn_on_delay_reg <= cmd.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.valid <= cmd.read || cmd.write;
			rsp_reg.error <= 1'b0;
			rsp_reg.rdata <= 16'h0000;
			if ((cmd.read || cmd.write) && !page_ok) begin
				rsp_reg.error <= 1'b1;  // see [RL13]
			end else if (cmd.read) begin
				case (cmd.command)
					CMD_INPUT_OVERCURRENT_RESPONSE: begin
						rsp_reg.rdata <= {8'h00, input_overcurrent_response_reg};
					end
					CMD_INPUT_OVERCURRENT_WARN_LIMIT: begin
						rsp_reg.rdata <= input_overcurrent_warning_limit_reg;
					end
					CMD_INPUT_OVERCURRENT_FAULT_LIMIT: begin
						rsp_reg.rdata <= input_overcurrent_fault_limit_reg;
					end
					CMD_TURN_ON_DELAY: begin
						rsp_reg.rdata <= turn_on_delay_reg;
					end
					default: begin
						rsp_reg.error <= 1'b1;
					end
				endcase
			end else if (cmd.write) begin
				case (cmd.command)
					CMD_INPUT_OVERCURRENT_RESPONSE, CMD_INPUT_OVERCURRENT_WARN_LIMIT,
					CMD_INPUT_OVERCURRENT_FAULT_LIMIT, CMD_TURN_ON_DELAY: begin
						rsp_reg.error <= 1'b0;
					end
					default: begin
						rsp_reg.error <= 1'b1;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Detection
	// ****************************************
	assign fault_now = $signed(input_current_reading) > $signed(input_overcurrent_fault_limit_reg);  // see [RL7] [RL14]
	assign warn_now  = $signed(input_current_reading) > $signed(input_overcurrent_warning_limit_reg); // see [RL9]

	assign fault_action_field = input_overcurrent_response_reg[ACTION_MSB:ACTION_LSB];
	assign retry_code         = input_overcurrent_response_reg[RETRY_MSB:RETRY_LSB];
	assign delay_code         = input_overcurrent_response_reg[DELAY_MSB:DELAY_LSB];

	// ****************************************
	// Delays
	// ****************************************
	always_comb begin
		if (delay_code == DELAY_CODE_MAX) begin
			retry_cycles = 32'(RETRY_MAX_CYCLES);  // see [RL6]
		end else begin
			retry_cycles = 32'(delay_code) * 32'(RETRY_STEP_CYCLES);  // see [RL6]
		end
	end

	assign ton_cycles = 32'(turn_on_delay_reg) * 32'(TON_STEP_CYCLES);  // see [RL11]

	// ****************************************
	// Output state machine
	// ****************************************
	always_comb begin
		state_next  = state_reg;
		timer_load  = 1'b0;
		timer_count = ton_cycles;
		case (state_reg)
			ST_OFF: begin
				if (enable && !shutdown_fault) begin
					state_next = ST_TON_WAIT;
					timer_load = 1'b1;  // see [RL11]
				end
			end
			ST_TON_WAIT: begin
				if (!enable || shutdown_fault) begin
					state_next = ST_OFF;
				end else if (!timer_busy) begin
					state_next = ST_ON;
				end
			end
			ST_ON: begin
				if (!enable || shutdown_fault) begin
					state_next = ST_OFF;
				end else if (fault_now && fault_action_field == ACTION_DISABLE) begin  // see [RL1]
					if (retry_code == RETRY_FOREVER) begin
						state_next  = ST_RETRY;  // see [RL4]
						timer_load  = 1'b1;
						timer_count = retry_cycles;  // see [RL5]
					end else begin
						state_next = ST_LATCHED;  // see [RL3]
					end
				end
			end
			ST_LATCHED: begin
				if (!enable || shutdown_fault) begin
					state_next = ST_OFF;  // see [RL3]
				end
			end
			ST_RETRY: begin
				if (!enable || shutdown_fault) begin
					state_next = ST_OFF;  // see [RL4]
				end else if (!timer_busy) begin
					state_next = ST_TON_WAIT;  // see [RL5]
					timer_load = 1'b1;
				end
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			out_en_reg <= 1'b0;
			ramp_reg   <= 1'b0;
		end else begin
			out_en_reg <= (state_next == ST_ON);
			ramp_reg   <= (state_reg == ST_TON_WAIT) && (state_next == ST_ON);  // see [RL11]
		end
	end

	// ****************************************
	// Status and alert
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			fault_st_reg <= 1'b0;
			warn_st_reg  <= 1'b0;
			alert_n_reg  <= 1'b1;
		end else begin
			fault_st_reg <= fault_now || (fault_st_reg && !clear_faults);  // see [RL2]
			warn_st_reg  <= warn_now || (warn_st_reg && !clear_faults);    // see [RL15]
			alert_n_reg  <= !(fault_now || warn_now || ((fault_st_reg || warn_st_reg) && !clear_faults));  // see [RL2] [RL15]
		end
	end

	iocr_timer u_timer (
		.clk   (clk),
		.reset (reset),
		.load  (timer_load),
		.count (timer_count),
		.busy  (timer_busy)
	);

	assign rsp             = rsp_reg;
	assign alert_out_n     = alert_n_reg;
	assign output_enable   = out_en_reg;
	assign ramp_start      = ramp_reg;
	assign oc_fault_status = fault_st_reg;
	assign oc_warn_status  = warn_st_reg;
endmodule

// [pkg/iocr_pkg.sv]
// Constants and types for the input overcurrent response and turn-on delay block
package iocr_pkg;

	// ****************************************
	// Command codes (page 0 only)
	// ****************************************
	localparam logic [7:0]  CMD_INPUT_OVERCURRENT_FAULT_LIMIT = 8'h5B;
	localparam logic [7:0]  CMD_INPUT_OVERCURRENT_RESPONSE    = 8'h5C;
	localparam logic [7:0]  CMD_INPUT_OVERCURRENT_WARN_LIMIT  = 8'h5D;
	localparam logic [7:0]  CMD_TURN_ON_DELAY                 = 8'h60;
	localparam logic [7:0]  PAGE_ZERO                         = 8'h00;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0]  RESPONSE_RESET   = 8'h04;
	localparam logic [15:0] WARN_LIMIT_RESET = 16'h3A98;
	localparam logic [15:0] FAULT_LIMIT_RESET = 16'h03E8;
	localparam logic [15:0] TURN_ON_DELAY_RESET  = 16'h0000;

	// ****************************************
	// Response field layout and codes
	// ****************************************
	localparam int          ACTION_MSB       = 7;
	localparam int          ACTION_LSB       = 6;
	localparam int          RETRY_MSB        = 5;
	localparam int          RETRY_LSB        = 3;
	localparam int          DELAY_MSB        = 2;
	localparam int          DELAY_LSB        = 0;
	localparam logic [1:0]  ACTION_CONTINUE  = 2'h0;
	localparam logic [1:0]  ACTION_DISABLE   = 2'h3;
	localparam logic [2:0]  RETRY_NONE       = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER    = 3'h7;
	localparam logic [2:0]  DELAY_CODE_MAX   = 3'h7;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_MHZ          = 100;
	localparam int          TON_STEP_US      = 10;
	localparam int          TON_STEP_CYCLES  = TON_STEP_US * CLK_MHZ;
	localparam int          RETRY_STEP_MS    = 25;
	localparam int          RETRY_MAX_MS     = 175;
	localparam int          RETRY_STEP_CYCLES = RETRY_STEP_MS * 1000 * CLK_MHZ;
	localparam int          RETRY_MAX_CYCLES = RETRY_MAX_MS * 1000 * CLK_MHZ;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic        write;
		logic        read;
		logic [7:0]  page;
		logic [7:0]  command;
		logic [15:0] wdata;
	} iocr_cmd_t;

	typedef struct packed {
		logic        valid;
		logic        error;
		logic [15:0] rdata;
	} iocr_rsp_t;

	typedef enum logic [4:0] {
		ST_OFF      = 5'h01,
		ST_TON_WAIT = 5'h02,
		ST_ON       = 5'h04,
		ST_LATCHED  = 5'h08,
		ST_RETRY    = 5'h10
	} iocr_state_t;

endpackage

// [logic/iocr_timer.sv]
// Down-counting delay timer in clock cycles
`timescale 1ns/100ps
module iocr_timer (
	input  wire logic        clk,    // System clock
	input  wire logic        reset,  // Synchronous reset, active high
	input  wire logic        load,   // Load a new count
	input  wire logic [31:0] count,  // Cycles to wait
	output logic             busy    // High while counting
);
	logic [31:0] remain_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			remain_reg <= 32'h0;
		end else if (load) begin
			remain_reg <= count;
		end else if (remain_reg != 32'h0) begin
			remain_reg <= remain_reg - 32'h1;
		end
	end

	assign busy = (remain_reg != 32'h0);
endmodule

// [test/iocr_asserts.sv]
// Port checker for the overcurrent response block
`timescale 1ns/100ps
module iocr_asserts
	import iocr_pkg::*;
(
	input wire logic      clk,             // Clock
	input wire logic      reset,           // Reset
	input wire iocr_cmd_t cmd,             // Command
	input wire logic      enable,          // Enable
	input wire logic      shutdown_fault,  // Shutdown
	input wire iocr_rsp_t rsp,             // Answer
	input wire logic      alert_out_n,     // Alert
	input wire logic      output_enable,   // Output on
	input wire logic      ramp_start,      // Ramp pulse
	input wire logic      oc_fault_status, // Fault
	input wire logic      oc_warn_status   // Warning
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	req_answered_a: assert property ((cmd.read || cmd.write) |=> rsp.valid) else $error("no answer");
	idle_silent_a: assert property (!(cmd.read || cmd.write) |=> !rsp.valid) else $error("stray answer");
	page_refused_a: assert property ((cmd.read || cmd.write) && cmd.page != PAGE_ZERO |=> rsp.error)
		else $error("foreign page taken");
	fault_alert_a: assert property (oc_fault_status |-> !alert_out_n) else $error("fault, no alert");
	warn_alert_a: assert property (oc_warn_status |-> !alert_out_n) else $error("warning, no alert");
	ramp_pulse_a: assert property (ramp_start |-> output_enable ##1 !ramp_start) else $error("bad ramp");
	enable_off_a: assert property (!enable |=> !output_enable) else $error("on while disabled");
	shutdown_off_a: assert property (shutdown_fault |=> !output_enable) else $error("on after shutdown");
	cover property (ramp_start);
	cover property (rsp.valid && rsp.error);
	cover property (oc_fault_status && !output_enable);
endmodule
bind iocr_top iocr_asserts u_iocr_asserts (.clk, .reset, .cmd, .enable, .shutdown_fault, .rsp, .alert_out_n,
	.output_enable, .ramp_start, .oc_fault_status, .oc_warn_status);

// [test/iocr_host.sv]
// Host model issuing commands to the block
`timescale 1ns/100ps
module iocr_host
	import iocr_pkg::*;
(
	input  wire logic      clk, // Clock
	input  wire iocr_rsp_t rsp, // Answer
	output iocr_cmd_t      cmd  // Command
);
	initial cmd = '0;
	task automatic xfer(input logic wr, input logic [7:0] pg, input logic [7:0] cm, input logic [15:0] wd,
		output logic [15:0] rd, output logic er, output logic ok);
		@(negedge clk);
		cmd = '{write: wr, read: !wr, page: pg, command: cm, wdata: wd};
		@(negedge clk);
		// Released fields show stale inverses so nothing relies on them
		cmd = '{write: 1'b0, read: 1'b0, page: ~pg, command: ~cm, wdata: ~wd};
		ok = rsp.valid;
		rd = rsp.rdata;
		er = rsp.error;
	endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the overcurrent response block
`timescale 1ns/100ps
module testbench
	import iocr_pkg::*;
;
	logic        clk, reset, en, sd, clr, alert_n, oe, ramp, flt, wrn;
	logic [15:0] cur;
	logic [31:0] rnd;
	iocr_cmd_t   cmd;
	iocr_rsp_t   rsp;
	int          compares, miscompares, n;
	logic [15:0] mdl [logic [7:0]];

	iocr_top u_iocr_top (.clk(clk), .reset(reset), .cmd(cmd), .input_current_reading(cur), .enable(en),
		.shutdown_fault(sd), .clear_faults(clr), .rsp(rsp), .alert_out_n(alert_n), .output_enable(oe),
		.ramp_start(ramp), .oc_fault_status(flt), .oc_warn_status(wrn));
	iocr_host u_iocr_host (.clk(clk), .rsp(rsp), .cmd(cmd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic wait_ramp(input int lim);
		for (n = 0; ramp !== 1'b1 && n < lim; n++) begin
			@(negedge clk);
		end
		if (ramp !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
	endtask

	// ****************************************
	// Register access against the model
	// ****************************************
	task automatic acc(input logic wr, input logic [7:0] pg, input logic [7:0] cm, input logic [15:0] wd);
		logic [15:0] rd;
		logic        er, ok, bad;
		bad = !(pg == PAGE_ZERO && mdl.exists(cm));
		u_iocr_host.xfer(wr, pg, cm, wd, rd, er, ok);
		chk({ok, er}, {1'b1, bad});
		if (!bad && wr) mdl[cm] = wd & (cm == CMD_INPUT_OVERCURRENT_RESPONSE ? 16'h00FF : 16'hFFFF);
		if (!bad && !wr) chk(rd, mdl[cm]);
	endtask

	task automatic power_up();
		en = 1'b0;
		idle(2);
		en = 1'b1;
		wait_ramp(10);
	endtask

	task automatic clear();
		clr = 1'b1;
		idle(1);
		clr = 1'b0;
		idle(2);
	endtask

	initial begin
		{reset, en, sd, clr, cur, rnd} = {4'h8, 16'h0000, 32'h48E507B9};
		mdl[CMD_INPUT_OVERCURRENT_RESPONSE] = 16'h0004;
		mdl[CMD_INPUT_OVERCURRENT_WARN_LIMIT] = 16'h3A98;
		mdl[CMD_INPUT_OVERCURRENT_FAULT_LIMIT] = 16'h03E8;
		mdl[CMD_TURN_ON_DELAY] = 16'h0000;
		idle(10);
		reset = 1'b0;
		foreach (mdl[k]) acc(1'b0, PAGE_ZERO, k, 16'h0000);
		for (int d = 2; d >= 0; d--) begin
			acc(1'b1, PAGE_ZERO, CMD_TURN_ON_DELAY, 16'(d));
			en = 1'b1;
			wait_ramp(3000);
			chk(16'(n), 16'(2 + d * TON_STEP_CYCLES));
			chk(oe, 1'b1);
			en = 1'b0;
			idle(2);
			chk(oe, 1'b0);
		end
		acc(1'b1, PAGE_ZERO, CMD_INPUT_OVERCURRENT_WARN_LIMIT, 16'hFFFB);
		power_up();
		idle(3);
		chk({wrn, alert_n, oe, flt}, 4'hA);
		acc(1'b1, PAGE_ZERO, CMD_INPUT_OVERCURRENT_WARN_LIMIT, 16'h7FFF);
		clear();
		chk({wrn, alert_n}, 2'b01);
		cur = 16'h03E8;
		idle(3);
		chk(flt, 1'b0);
		cur = 16'h03E9;
		idle(3);
		chk({flt, alert_n, oe}, 3'b101);
		cur = 16'h0000;
		// Latched off, retry at once, then retry held off by the longest delay
		for (int r = 0; r < 3; r++) begin
			acc(1'b1, PAGE_ZERO, CMD_INPUT_OVERCURRENT_RESPONSE, (r == 0) ? 16'h00C0 : (r == 1) ? 16'h00F8 : 16'h00FF);
			power_up();
			clear();
			cur = 16'h03E9;
			idle(1);
			cur = 16'h0000;
			chk({flt, alert_n}, 2'b10);
			if (r == 1) begin
				wait_ramp(20);
				chk(oe, 1'b1);
				sd = 1'b1;
				idle(2);
				chk(oe, 1'b0);
				sd = 1'b0;
			end else begin
				idle(200);
				chk(oe, 1'b0);
			end
		end
		en = 1'b0;
		acc(1'b1, 8'h01, CMD_TURN_ON_DELAY, 16'h1234);
		acc(1'b1, PAGE_ZERO, 8'h61, 16'h1234);
		repeat (3) foreach (mdl[k]) begin
			rnd = lfsr(rnd);
			cur = rnd[31:16];
			acc(1'b1, PAGE_ZERO, k, rnd[15:0]);
			acc(1'b0, PAGE_ZERO, k, 16'h0000);
		end
		end_of_test();
	end
endmodule
